/* hdl/gls_lock_status.sv */
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - lock engages only with solenoid and electronics supply both present
// - removing either supply releases the lock at once
// - solenoid on and actuator fully inserted gives locked state
// - locked state drives both safety outputs, lock and both door flags
// - closed unlocked: outputs off active, on optional; open: off
// - lock flag only in locked state
// - first door flag in every closed state, off when open
// - second door flag when locked or ready; off otherwise
// - solenoid off when closed unlocked; ignored while open
// - auxiliary release unlocks regardless of solenoid supply
// - active monitoring: manual release clears lock flag and safety outputs
// - optional monitoring: release clears lock and second door flags, outputs stay on; indicators blink
// - after release reset, normal once guard opened and closed again or solenoid removed
// - escape knob press is release; pulling it out resets it
// - optional monitoring: outputs off at assured release distance
// - release flag set on release, cleared when command matches lock
module gls_lock_status #(
    parameter int BLINK_CYC = gls_pkg::GLS_BLINK_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic mon_optional,
    input  wire logic sol_supply,
    input  wire logic elec_supply,
    input  wire logic act_inserted,
    input  wire logic act_full,
    input  wire logic aux_release,
    input  wire logic esc_pressed,
    input  wire logic act_released_dist,
    output logic      safety_out_a,
    output logic      safety_out_b,
    output logic      lock_engaged_flag,
    output logic      door_pos_first_flag,
    output logic      door_pos_second_flag,
    output logic      manual_release_flag,
    output logic      state_led_white,
    output logic      state_led_orange,
    output logic      lock_led_orange
);
    // the blink divider needs at least two counts per phase
    generate
        if (BLINK_CYC < 2)
        begin : g_bad_blink
            $error("BLINK_CYC too small");
        end
    endgenerate

    localparam int CW = $clog2(BLINK_CYC);

    // raw pins gathered for one synchroniser array
    logic [gls_pkg::GLS_NUM_IN-1:0] raw;
    logic [gls_pkg::GLS_NUM_IN-1:0] meta;
    logic [gls_pkg::GLS_NUM_IN-1:0] sy;
    assign raw = {act_released_dist, esc_pressed, aux_release, act_full,
                  act_inserted, elec_supply, sol_supply};

    // two-stage synchronisers, first stage read only by second
    genvar gi;
    generate
        for (gi = 0; gi < gls_pkg::GLS_NUM_IN; gi++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    meta[gi] <= 1'b0;
                    sy[gi]   <= 1'b0;
                end
                else
                begin
                    meta[gi] <= raw[gi];
                    sy[gi]   <= meta[gi];
                end
            end
        end
    endgenerate

    logic s_sol, s_elec, s_ins, s_full, s_aux, s_esc, s_ar;
    assign s_sol  = sy[gls_pkg::GLS_IN_SOL];
    assign s_elec = sy[gls_pkg::GLS_IN_ELEC];
    assign s_ins  = sy[gls_pkg::GLS_IN_INS];
    assign s_full = sy[gls_pkg::GLS_IN_FULL];
    assign s_aux  = sy[gls_pkg::GLS_IN_AUX];
    assign s_esc  = sy[gls_pkg::GLS_IN_ESC];
    assign s_ar   = sy[gls_pkg::GLS_IN_AR];

    // escape knob pressed counts as a release, pulled out as reset
    logic release_act;
    assign release_act = s_aux | s_esc;

    // latched release: cleared once released and guard reclosed or solenoid off
    logic rel_latched;
    logic rel_reset_seen;
    logic was_open;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rel_latched    <= 1'b0;
            rel_reset_seen <= 1'b0;
            was_open       <= 1'b0;
        end
        else if (release_act)
        begin
            // new actuation wins over any pending recovery
            rel_latched    <= 1'b1;
            rel_reset_seen <= 1'b0;
            was_open       <= 1'b0;
        end
        else if (rel_latched)
        begin
            rel_reset_seen <= 1'b1;
            if (!s_ins)
            begin
                was_open <= 1'b1;
            end
            if (rel_reset_seen && ((was_open && s_ins) || !s_sol))
            begin
                rel_latched <= 1'b0;
                was_open    <= 1'b0;
            end
        end
    end

    // lock condition: both supplies, full insertion, no release
    // a fresh release blocks the lock before the latch has caught it
    logic lock_ok;
    assign lock_ok = s_sol && s_elec && s_full && s_ins && !rel_latched && !release_act;

    gls_pkg::gls_state_t next_state;
    always_comb
    begin
        if (!s_ins || s_ar)
        begin
            next_state = gls_pkg::GLS_OPEN;
        end
        else if (lock_ok)
        begin
            next_state = gls_pkg::GLS_LOCKED;
        end
        else if (s_full && !rel_latched && !release_act)
        begin
            next_state = gls_pkg::GLS_READY;
        end
        else
        begin
            next_state = gls_pkg::GLS_CLOSED;
        end
    end

    gls_pkg::gls_state_t state;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= gls_pkg::GLS_OPEN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // output flags, registered from the next state
    logic closed_n, safe_n;
    always_comb
    begin
        closed_n = (next_state != gls_pkg::GLS_OPEN);
        unique case (next_state)
            gls_pkg::GLS_LOCKED: safe_n = 1'b1;
            gls_pkg::GLS_OPEN:   safe_n = 1'b0;
            gls_pkg::GLS_READY,
            gls_pkg::GLS_CLOSED: safe_n = mon_optional;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            safety_out_a         <= 1'b0;
            safety_out_b         <= 1'b0;
            lock_engaged_flag    <= 1'b0;
            door_pos_first_flag  <= 1'b0;
            door_pos_second_flag <= 1'b0;
        end
        else
        begin
            safety_out_a         <= safe_n;
            safety_out_b         <= safe_n;
            lock_engaged_flag    <= (next_state == gls_pkg::GLS_LOCKED);
            door_pos_first_flag  <= closed_n;
            door_pos_second_flag <= (next_state == gls_pkg::GLS_LOCKED) ||
                                    (next_state == gls_pkg::GLS_READY);
        end
    end

    // release flag: command (solenoid) vs actual lock mismatch
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            manual_release_flag <= 1'b0;
        end
        else if (release_act)
        begin
            manual_release_flag <= 1'b1;
        end
        else if (manual_release_flag && (s_sol == (next_state == gls_pkg::GLS_LOCKED)))
        begin
            manual_release_flag <= 1'b0;
        end
    end

    // slow blink generator, free running
    logic [CW-1:0] blink_cnt;
    logic          blink;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            blink_cnt <= '0;
            blink     <= 1'b0;
        end
        else if (blink_cnt == CW'(BLINK_CYC - 1))
        begin
            blink_cnt <= '0;
            blink     <= ~blink;
        end
        else
        begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // indicators only during optional-monitoring release
    logic ind_on;
    assign ind_on = mon_optional && rel_latched;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_led_white  <= 1'b0;
            state_led_orange <= 1'b0;
            lock_led_orange  <= 1'b0;
        end
        else
        begin
            state_led_white  <= ind_on && !blink;
            state_led_orange <= ind_on && blink;
            lock_led_orange  <= ind_on && blink;
        end
    end

    // checks
    a_lock_needs_supply: assert property (@(posedge clk) disable iff (rst)
        lock_engaged_flag |-> $past(s_sol) && $past(s_elec))
        else $error("lock without supply");
    a_supply_loss_rel: assert property (@(posedge clk) disable iff (rst)
        !s_elec |=> !lock_engaged_flag)
        else $error("lock held without electronics supply");
    a_lock_when_ready: assert property (@(posedge clk) disable iff (rst)
        (s_sol && s_elec && s_full && s_ins && !s_ar && !rel_latched && !release_act)
        |=> lock_engaged_flag)
        else $error("lock not engaged");
    a_locked_outputs: assert property (@(posedge clk) disable iff (rst)
        lock_engaged_flag |-> safety_out_a && safety_out_b && door_pos_first_flag
                              && door_pos_second_flag)
        else $error("locked outputs wrong");
    a_closed_unlocked: assert property (@(posedge clk) disable iff (rst)
        (door_pos_first_flag && !lock_engaged_flag && $past(mon_optional) == 1'b0)
        |-> !safety_out_a)
        else $error("active monitoring outputs on while unlocked");
    a_open_all_off: assert property (@(posedge clk) disable iff (rst)
        !$past(s_ins) |-> !door_pos_first_flag && !safety_out_b && !lock_engaged_flag)
        else $error("open guard outputs on");
    a_aux_releases: assert property (@(posedge clk) disable iff (rst)
        s_aux |=> !lock_engaged_flag ##1 !lock_engaged_flag)
        else $error("aux release ignored");
    a_release_flag: assert property (@(posedge clk) disable iff (rst)
        release_act |=> manual_release_flag)
        else $error("release flag not set");
    a_sar_shutdown: assert property (@(posedge clk) disable iff (rst)
        s_ar |=> !safety_out_a && !safety_out_b)
        else $error("outputs on at release distance");
    a_opt_closed_on: assert property (@(posedge clk) disable iff (rst)
        (door_pos_first_flag && !lock_engaged_flag && $past(mon_optional))
        |-> safety_out_a && safety_out_b)
        else $error("optional monitoring outputs off while closed");
    a_door2_closed: assert property (@(posedge clk) disable iff (rst)
        door_pos_second_flag |-> door_pos_first_flag)
        else $error("second door flag while open");
    a_led_idle: assert property (@(posedge clk) disable iff (rst)
        !$past(mon_optional) |-> !state_led_white && !state_led_orange && !lock_led_orange)
        else $error("indicators on under active monitoring");

    c_locked: cover property (@(posedge clk) disable iff (rst) lock_engaged_flag);
    c_opt_release: cover property (@(posedge clk) disable iff (rst)
        mon_optional && lock_engaged_flag ##[1:20] safety_out_a && !lock_engaged_flag);
    c_recover: cover property (@(posedge clk) disable iff (rst)
        $fell(rel_latched) ##[1:20] lock_engaged_flag);
    c_ready_lock: cover property (@(posedge clk) disable iff (rst)
        state == gls_pkg::GLS_READY ##1 state == gls_pkg::GLS_LOCKED);
endmodule
`default_nettype wire

/* hdl/gls_pkg.sv */
package gls_pkg;
    // lock monitoring configuration
    typedef enum logic [0:0]
    {
        GLS_MON_ACTIVE   = 1'b0,
        GLS_MON_OPTIONAL = 1'b1
    } gls_mon_t;

    // door / lock states
    typedef enum logic [1:0]
    {
        GLS_OPEN        = 2'b00,
        GLS_CLOSED      = 2'b01,
        GLS_READY       = 2'b10,
        GLS_LOCKED      = 2'b11
    } gls_state_t;

    // synchroniser depth
    localparam int GLS_SYNC_STAGES = 2;
    // number of raw asynchronous inputs
    localparam int GLS_NUM_IN      = 7;
    // bit positions in the raw input vector
    localparam int GLS_IN_SOL      = 0;
    localparam int GLS_IN_ELEC     = 1;
    localparam int GLS_IN_INS      = 2;
    localparam int GLS_IN_FULL     = 3;
    localparam int GLS_IN_AUX      = 4;
    localparam int GLS_IN_ESC      = 5;
    localparam int GLS_IN_AR       = 6;
    // slow blink phase length, half the blink period
    localparam int GLS_BLINK_NS    = 500_000_000;
    localparam int GLS_CLK_NS      = 10;
    localparam int GLS_BLINK_CYC   = GLS_BLINK_NS / GLS_CLK_NS;
endpackage

/* test/gls_safety_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module gls_safety_ctrl (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic lock_cmd,
    input  wire logic safety_out_a,
    input  wire logic safety_out_b,
    output logic      sol_supply,
    output logic      pair_fault
);
    // controller switches the solenoid supply straight from its lock command
    assign sol_supply = lock_cmd;

    // two-channel evaluation: any split between channels, even for one cycle, is latched
    always_ff @(posedge clk)
    begin
        if (rst)
            pair_fault <= 1'b0;
        else if (safety_out_a !== safety_out_b)
            pair_fault <= 1'b1;
    end
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic       clk;
    logic       rst;
    logic       mon_optional;
    logic       lock_cmd;
    logic       sol_supply;
    logic       elec_supply;
    logic       act_inserted;
    logic       act_full;
    logic       aux_release;
    logic       esc_pressed;
    logic       act_released_dist;
    logic       safety_out_a;
    logic       safety_out_b;
    logic       lock_engaged_flag;
    logic       door_pos_first_flag;
    logic       door_pos_second_flag;
    logic       manual_release_flag;
    logic       state_led_white;
    logic       state_led_orange;
    logic       lock_led_orange;
    logic       pair_fault;
    logic [2:0] seen;
    int         err_count;
    int         comparisons;
    logic       m;

    // short blink period keeps the indicator check within a few cycles
    gls_lock_status #(.BLINK_CYC(4)) i_gls_lock_status (.clk(clk), .rst(rst),
        .mon_optional(mon_optional), .sol_supply(sol_supply), .elec_supply(elec_supply),
        .act_inserted(act_inserted), .act_full(act_full), .aux_release(aux_release),
        .esc_pressed(esc_pressed), .act_released_dist(act_released_dist),
        .safety_out_a(safety_out_a), .safety_out_b(safety_out_b),
        .lock_engaged_flag(lock_engaged_flag), .door_pos_first_flag(door_pos_first_flag),
        .door_pos_second_flag(door_pos_second_flag),
        .manual_release_flag(manual_release_flag), .state_led_white(state_led_white),
        .state_led_orange(state_led_orange), .lock_led_orange(lock_led_orange));
    gls_safety_ctrl i_gls_safety_ctrl (.clk(clk), .rst(rst), .lock_cmd(lock_cmd),
        .safety_out_a(safety_out_a), .safety_out_b(safety_out_b),
        .sol_supply(sol_supply), .pair_fault(pair_fault));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // inputs {cmd,elec,ins,full,aux,esc,dist}; sync and output register take three edges,
    // a latched release clears one edge later, so four edges before looking
    task automatic drive(input logic [6:0] v);
        @(negedge clk);
        {lock_cmd, elec_supply, act_inserted, act_full} = v[6:3];
        {aux_release, esc_pressed, act_released_dist} = v[2:0];
        repeat (4) @(negedge clk);
    endtask

    // expected {out_a,out_b,lock,door1,door2,release}
    task automatic check(input logic [5:0] exp);
        logic [5:0] got;
        got = {safety_out_a, safety_out_b, lock_engaged_flag, door_pos_first_flag,
               door_pos_second_flag, manual_release_flag};
        comparisons++;
        if (got !== exp)
        begin
            $display("[FAIL] outputs expected %b seen %b", exp, got);
            err_count++;
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        err_count = 0;
        comparisons = 0;
        rst = 1'b1;
        mon_optional = 1'b0;
        {lock_cmd, elec_supply, act_inserted, act_full} = 4'h0;
        {aux_release, esc_pressed, act_released_dist} = 3'h0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(6'h00);
        // both monitoring modes walk the same state table
        for (int k = 0; k < 2; k++)
        begin
            m = k[0];
            mon_optional = m;
            drive(7'h40); check(6'h00);
            drive(7'h30); check({m, m, 4'h4});
            drive(7'h38); check({m, m, 4'h6});
            drive(7'h78); check(6'h3E);
            drive(7'h58); check({m, m, 4'h6});
            drive(7'h78); check(6'h3E);
            drive(7'h7C); check({m, m, 4'h5});
            // indicators light only under optional monitoring
            comparisons++;
            if ((|{state_led_white, state_led_orange, lock_led_orange}) !== m)
            begin
                $display("[FAIL] indicators lit expected %b seen %b", m,
                         {state_led_white, state_led_orange, lock_led_orange});
                err_count++;
            end
            drive(7'h78); check({m, m, 4'h5});
            drive(7'h38); check({m, m, 4'h6});
            drive(7'h00); check(6'h00);
        end
        // escape knob under optional monitoring, indicators must blink
        drive(7'h78); check(6'h3E);
        drive(7'h7A); check(6'h35);
        seen = 3'h0;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            seen = seen | {state_led_white, state_led_orange, lock_led_orange};
            // white and orange alternate, lock lamp follows orange
            comparisons++;
            if (state_led_white === state_led_orange ||
                lock_led_orange !== state_led_orange)
            begin
                $display("[FAIL] blink phase expected 100 or 011 seen %b",
                         {state_led_white, state_led_orange, lock_led_orange});
                err_count++;
            end
        end
        comparisons++;
        if (seen !== 3'h7)
        begin
            $display("[FAIL] blink expected 111 seen %b", seen);
            err_count++;
        end
        drive(7'h78); check(6'h35);
        drive(7'h40); check(6'h01);
        drive(7'h78); check(6'h3E);
        drive(7'h79); check(6'h00);
        comparisons++;
        if (pair_fault !== 1'b0)
        begin
            $display("[FAIL] pair_fault expected 0 seen %b", pair_fault);
            err_count++;
        end
        end_of_test();
    end
endmodule
`default_nettype wire
